// ### hw/stpi_pkg.sv
// Shared constants, types and layouts of the serial transmitter host input port
package stpi_pkg;

  // Level seen on a three-level strap pin (ground, supply, floating or mid-supply)
  typedef enum logic [1:0] {
    STPI_LVL_GND = 2'b00,
    STPI_LVL_VCC = 2'b01,
    STPI_LVL_MID = 2'b10
  } stpi_level_t;

  // One host byte as held in the input latch and the buffer
  typedef struct packed {
    logic is_cmd;      // Command byte instead of data
    logic [9:0] data;  // Data bits, unused upper bits zero
    logic [3:0] cmd;   // Command bits, unused upper bits zero
  } stpi_word_t;

  localparam int STPI_WORD_W = 15;

  // Register byte offsets on the bus
  localparam logic [3:0] STPI_REG_CTRL = 4'h0;
  localparam logic [3:0] STPI_REG_STATUS = 4'h4;
  localparam logic [3:0] STPI_REG_COUNT = 4'h8;

  // Control register layout and reset value
  localparam int STPI_CTRL_EN_BIT = 0;
  localparam logic [31:0] STPI_CTRL_RST = 32'h0000_0001;

  // Status register field positions
  localparam int STPI_ST_LATCH_BIT = 0;
  localparam int STPI_ST_FILL_LSB = 1;
  localparam int STPI_ST_LOCK_BIT = 3;
  localparam int STPI_ST_MODE_LSB = 4;
  localparam int STPI_ST_SPLIT_LSB = 6;
  localparam int STPI_ST_ACK_BIT = 8;

  // Timing: clock period and relock time after a PLL reset pulse
  localparam int STPI_MCLK_PERIOD_PS = 5000;
  localparam int STPI_LOCK_TIME_NS = 1000;
  localparam int STPI_LOCK_CYC =
    (STPI_LOCK_TIME_NS * 1000 + STPI_MCLK_PERIOD_PS - 1) / STPI_MCLK_PERIOD_PS;
  localparam int STPI_BIT_CYC = 4;

  // Serial symbol lengths per byte for the three width splits
  localparam logic [3:0] STPI_LEN_8 = 4'h0a;
  localparam logic [3:0] STPI_LEN_9 = 4'h0b;
  localparam logic [3:0] STPI_LEN_10 = 4'h0c;

  // Reserved group codes: sync pair and command marker, none a data code
  localparam logic [4:0] STPI_SYNC5_HI = 5'h18;
  localparam logic [4:0] STPI_SYNC5_LO = 5'h11;
  localparam logic [4:0] STPI_CMD5_MARK = 5'h07;
  localparam logic [5:0] STPI_SYNC6_HI = 6'h3f;
  localparam logic [5:0] STPI_SYNC6_LO = 6'h00;
  localparam logic [5:0] STPI_CMD6_MARK = 6'h1e;

endpackage

// ### hw/stpi_buffer.sv
// Small valid/ready buffer between the host input latch and the encoder
`timescale 1ns/1ps
`default_nettype none
module stpi_buffer #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [1:0] fill
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];  // Entry storage
  logic [AW-1:0] wr_ptr;          // Next slot to write
  logic [AW-1:0] rd_ptr;          // Oldest slot
  logic [AW:0] count;             // Entries held
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign fill = 2'(count);

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// ### hw/stpi_port.sv
// Host parallel input port, encoder and serializer of the serial link transmitter
// Behaviour
// - Acknowledge high only when byte accepted
// - Empty latch: store at once, quick acknowledge
// - Full latch: acknowledge waits for clock fall
// - Any command bit set sends command
// - Split select gives 8/4, 9/3, 10/2
// - Local mode drives free-running byte clock
// - Test modes take clock pin as input
// - Reset pin low restarts PLL lock
// - Group-code bytes, NRZI on the line in local mode
// - Inputs captured at strobe rise, or at clock fall if latch full
// - Mode select picks local or tests
`timescale 1ns/1ps
`default_nettype none
module stpi_port #(
  parameter int BIT_CYC = stpi_pkg::STPI_BIT_CYC,
  parameter int LOCK_CYC = stpi_pkg::STPI_LOCK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  // Host side
  input wire logic host_load_strobe,
  input wire logic [7:0] data_in_low,
  input wire logic [1:0] command_in_low,
  input wire logic shared_bit_eight,
  input wire logic shared_bit_nine,
  output logic host_ack,
  // Straps
  input wire logic [1:0] width_split_select,
  input wire logic [1:0] test_or_normal_select,
  // Byte clock pin, two-way
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  // PLL reset pin, open drain with pull-up
  input wire logic pll_reset_in,
  output logic pll_reset_out,
  output logic pll_reset_oe,
  // Serial line
  output logic serial_out,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // 4-bit to 5-bit group code
  function automatic logic [4:0] enc5(input logic [3:0] n);
    case (n)
      4'h0: enc5 = 5'h1e;
      4'h1: enc5 = 5'h09;
      4'h2: enc5 = 5'h14;
      4'h3: enc5 = 5'h15;
      4'h4: enc5 = 5'h0a;
      4'h5: enc5 = 5'h0b;
      4'h6: enc5 = 5'h0e;
      4'h7: enc5 = 5'h0f;
      4'h8: enc5 = 5'h12;
      4'h9: enc5 = 5'h13;
      4'ha: enc5 = 5'h16;
      4'hb: enc5 = 5'h17;
      4'hc: enc5 = 5'h1a;
      4'hd: enc5 = 5'h1b;
      4'he: enc5 = 5'h1c;
      default: enc5 = 5'h1d;
    endcase
  endfunction

  // 5-bit to 6-bit group code; first bit always differs from last
  function automatic logic [5:0] enc6(input logic [4:0] n);
    enc6 = {~n[0], n};
  endfunction

  // Symbol bits per byte for a width split
  function automatic logic [3:0] byte_len(input logic [1:0] split);
    case (split)
      stpi_pkg::STPI_LVL_GND: byte_len = stpi_pkg::STPI_LEN_8;
      stpi_pkg::STPI_LVL_VCC: byte_len = stpi_pkg::STPI_LEN_9;
      default: byte_len = stpi_pkg::STPI_LEN_10;
    endcase
  endfunction

  // Encode a word (or sync when idle) into left-aligned 12 code bits
  function automatic logic [11:0] encode(input stpi_pkg::stpi_word_t w,
                                         input logic idle, input logic [1:0] split);
    logic [11:0] c;
    c = '0;
    case (split)
      stpi_pkg::STPI_LVL_GND: begin
        if (idle) c = {stpi_pkg::STPI_SYNC5_HI, stpi_pkg::STPI_SYNC5_LO, 2'b00};
        else if (w.is_cmd) c = {stpi_pkg::STPI_CMD5_MARK, enc5(w.cmd), 2'b00};
        else c = {enc5(w.data[7:4]), enc5(w.data[3:0]), 2'b00};
      end
      stpi_pkg::STPI_LVL_VCC: begin
        if (idle) c = {enc6(5'h00), stpi_pkg::STPI_SYNC5_LO, 1'b0};
        else if (w.is_cmd) c = {enc6(5'h1f), enc5(w.cmd), 1'b0};
        else c = {enc6(w.data[8:4]), enc5(w.data[3:0]), 1'b0};
      end
      default: begin
        if (idle) c = {stpi_pkg::STPI_SYNC6_HI, stpi_pkg::STPI_SYNC6_LO};
        else if (w.is_cmd) c = {stpi_pkg::STPI_CMD6_MARK, enc6({1'b0, w.cmd})};
        else c = {enc6(w.data[9:5]), enc6(w.data[4:0])};
      end
    endcase
    encode = c;
  endfunction

  localparam int DW = (BIT_CYC > 1) ? $clog2(BIT_CYC) : 1;
  localparam int LW = $clog2(LOCK_CYC + 1);

  // Host side state
  logic strobe_q;                  // Strobe one cycle ago
  logic pending;                   // Strobe seen while latch was full
  logic latch_full;                // Input latch holds a byte
  stpi_pkg::stpi_word_t latch;     // Input latch
  stpi_pkg::stpi_word_t host_word; // Present inputs as a word
  logic strobe_rise;
  logic capture;

  // Encoder side state
  logic [31:0] ctrl;               // Control register
  logic [15:0] sent_count;         // Host bytes sent on the line
  logic [LW-1:0] lock_cnt;         // Relock countdown
  logic locked;
  logic [DW-1:0] div_cnt;          // Bit period divider
  logic [3:0] bit_cnt;             // Bit within byte
  logic [11:0] shifter;            // Code bits, MSB first
  logic clk_in_q;                  // Clock pin one cycle ago
  logic bit_tick;
  logic byte_edge;
  logic [3:0] len;
  logic local_mode;
  logic test1;
  logic test2;
  logic bus_ack;                   // Bus answer cycle

  // Buffer wiring
  localparam int STPI_WORD_W_L = stpi_pkg::STPI_WORD_W;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [STPI_WORD_W_L-1:0] buf_out_data;
  logic [1:0] buf_fill;
  logic take;
  stpi_pkg::stpi_word_t buf_word;

  assign local_mode = (test_or_normal_select == stpi_pkg::STPI_LVL_GND);
  assign test1 = (test_or_normal_select == stpi_pkg::STPI_LVL_VCC);
  assign test2 = !local_mode && !test1;
  assign len = byte_len(width_split_select);
  assign buf_word = stpi_pkg::stpi_word_t'(buf_out_data);

  // Map the pins to data and command by the width split
  always_comb begin
    host_word = '0;
    host_word.data[7:0] = data_in_low;
    case (width_split_select)
      stpi_pkg::STPI_LVL_GND: begin
        host_word.cmd = {shared_bit_eight, shared_bit_nine, command_in_low};
      end
      stpi_pkg::STPI_LVL_VCC: begin
        host_word.data[8] = shared_bit_eight;
        host_word.cmd[2:0] = {shared_bit_nine, command_in_low};
      end
      default: begin
        host_word.data[9:8] = {shared_bit_nine, shared_bit_eight};
        host_word.cmd[1:0] = command_in_low;
      end
    endcase
    host_word.is_cmd = (host_word.cmd != 4'h0);
    if (host_word.is_cmd) begin
      host_word.data = '0;
    end
  end

  // Bit and byte timing by mode
  always_comb begin
    if (test2) begin
      bit_tick = clk_pin_in && !clk_in_q;
    end else begin
      bit_tick = locked && (div_cnt == DW'(BIT_CYC - 1));
    end
    if (test1) begin
      byte_edge = clk_in_q && !clk_pin_in;
    end else begin
      byte_edge = bit_tick && (bit_cnt == len - 4'h1);
    end
  end

  assign strobe_rise = host_load_strobe && !strobe_q;
  // Latch empty or emptied this cycle at the clock fall
  assign capture = host_load_strobe && (strobe_rise || pending) &&
                   (!latch_full || (byte_edge && buf_in_ready));
  assign take = byte_edge && ctrl[stpi_pkg::STPI_CTRL_EN_BIT] && buf_out_valid;

  // Strobe edge history and clock pin history
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= 1'b0;
      clk_in_q <= 1'b0;
    end else begin
      strobe_q <= host_load_strobe;
      clk_in_q <= clk_pin_in;
    end
  end

  // Input latch and acknowledge handshake
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch <= '0;
      latch_full <= 1'b0;
      pending <= 1'b0;
      host_ack <= 1'b0;
    end else begin
      if (capture) begin
        latch <= host_word;
        latch_full <= 1'b1;
      end else if (byte_edge && buf_in_ready) begin
        latch_full <= 1'b0;
      end
      if (!host_load_strobe || capture) begin
        pending <= 1'b0;
      end else if (strobe_rise) begin
        pending <= 1'b1;
      end
      if (!host_load_strobe) begin
        host_ack <= 1'b0;
      end else if (capture) begin
        host_ack <= 1'b1;
      end
    end
  end

  // Relock after a low pulse on the PLL reset pin
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt <= LW'(LOCK_CYC);
      locked <= 1'b0;
    end else if (!pll_reset_in) begin
      lock_cnt <= LW'(LOCK_CYC);
      locked <= 1'b0;
    end else if (lock_cnt != '0) begin
      lock_cnt <= lock_cnt - LW'(1);
    end else begin
      locked <= 1'b1;
    end
  end

  // Bit divider and bit counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      bit_cnt <= '0;
    end else begin
      if (!locked || bit_tick) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + DW'(1);
      end
      if (!locked && !test2) begin
        bit_cnt <= '0;
      end else if (byte_edge) begin
        bit_cnt <= '0;
      end else if (bit_tick && bit_cnt != len) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Shifter, line coding and sent counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shifter <= '0;
      serial_out <= 1'b0;
      sent_count <= '0;
    end else begin
      if (bit_tick) begin
        if (local_mode) begin
          serial_out <= serial_out ^ shifter[11];
        end else begin
          serial_out <= shifter[11];
        end
      end
      if (byte_edge) begin
        shifter <= encode(buf_word, !take, width_split_select);
      end else if (bit_tick) begin
        shifter <= {shifter[10:0], 1'b0};
      end
      if (take) begin
        sent_count <= sent_count + 16'h0001;
      end
    end
  end

  // Byte clock pin: driven only in local mode, falls at each byte boundary
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b0;
      pll_reset_out <= 1'b0;
      pll_reset_oe <= 1'b0;
    end else begin
      clk_pin_oe <= local_mode;
      if (byte_edge) begin
        clk_pin_out <= 1'b0;
      end else if (bit_tick && bit_cnt == {1'b0, len[3:1]} - 4'h1) begin
        clk_pin_out <= 1'b1;
      end
      pll_reset_out <= 1'b0;
      pll_reset_oe <= 1'b0;
    end
  end

  // Two-entry buffer between the input latch and the encoder
  stpi_buffer #(
    .WIDTH(STPI_WORD_W_L),
    .DEPTH(2)
  ) u_buffer (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(latch_full && byte_edge),
    .in_ready(buf_in_ready),
    .in_data(latch),
    .out_valid(buf_out_valid),
    .out_ready(take),
    .out_data(buf_out_data),
    .fill(buf_fill)
  );

  // Bus slave: one wait cycle, then the answer cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      if (bus_ack) begin
        bus_ack <= 1'b0;
        avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
        bus_ack <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_readdata <= '0;
        if (avs_read) begin
          case (avs_address)
            stpi_pkg::STPI_REG_CTRL: avs_readdata <= ctrl;
            stpi_pkg::STPI_REG_STATUS: begin
              avs_readdata[stpi_pkg::STPI_ST_LATCH_BIT] <= latch_full;
              avs_readdata[stpi_pkg::STPI_ST_FILL_LSB +: 2] <= buf_fill;
              avs_readdata[stpi_pkg::STPI_ST_LOCK_BIT] <= locked;
              avs_readdata[stpi_pkg::STPI_ST_MODE_LSB +: 2] <= test_or_normal_select;
              avs_readdata[stpi_pkg::STPI_ST_SPLIT_LSB +: 2] <= width_split_select;
              avs_readdata[stpi_pkg::STPI_ST_ACK_BIT] <= host_ack;
            end
            stpi_pkg::STPI_REG_COUNT: avs_readdata <= {16'h0000, sent_count};
            default: avs_readdata <= '0;
          endcase
        end
      end
    end
  end

  // Control register write on the answer cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= stpi_pkg::STPI_CTRL_RST;
    end else if (bus_ack && avs_write && avs_address == stpi_pkg::STPI_REG_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          ctrl[i*8 +: 8] <= (i == 0) ? {7'h00, avs_writedata[0]} : 8'h00;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/stpi_port_properties.sv
// Pin-level checks on the host input port
`timescale 1ns/1ps
`default_nettype none
module stpi_port_properties (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic host_load_strobe,
  input wire logic host_ack,
  input wire logic [1:0] test_or_normal_select,
  input wire logic clk_pin_oe,
  input wire logic pll_reset_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Request that the slave takes on this edge
  sequence bus_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // One wait state, answer stands one cycle
  sequence bus_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_ack_needs_strobe: assert property ($rose(host_ack) |-> $past(host_load_strobe))
    else $error("ack rose without strobe");
  chk_ack_holds: assert property (host_ack && host_load_strobe |=> host_ack)
    else $error("ack dropped under strobe");
  chk_ack_release: assert property (host_ack && !host_load_strobe |=> !host_ack)
    else $error("ack stayed after strobe fell");
  // Sampled reset in the antecedent: the port still resets on the release edge itself
  chk_oe_local: assert property (rst_b && test_or_normal_select == 2'b00 |=> clk_pin_oe)
    else $error("clock pin not driven in local mode");
  chk_oe_test: assert property (test_or_normal_select != 2'b00 |=> !clk_pin_oe)
    else $error("clock pin driven in test mode");
  chk_pll_hands_off: assert property (!pll_reset_oe)
    else $error("relock pin driven");
  chk_bus_one_wait: assert property (bus_taken |=> bus_answer)
    else $error("bus answer timing");
  chk_bus_idle_wait: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest fell with no request");
  chk_unmapped_zero: assert property ((bus_taken and (avs_read
    && !(avs_address inside {4'h0, 4'h4, 4'h8}))) |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_ctrl_upper_zero: assert property ((bus_taken and (avs_read && avs_address == 4'h0))
    |=> avs_readdata[31:1] == 31'h0)
    else $error("control upper bits not zero");
endmodule
`default_nettype wire

// ### tb/stpi_host_model.sv
// Host logic that strobes words into the port
`timescale 1ns/1ps
`default_nettype none
module stpi_host_model (
  input wire logic mclk,
  input wire logic [1:0] split,
  output logic host_load_strobe,
  output logic [7:0] data_in_low,
  output logic [1:0] command_in_low,
  output logic shared_bit_eight,
  output logic shared_bit_nine,
  input wire logic host_ack
);
  logic [11:0] pins;  // All twelve host bits
  assign {shared_bit_nine, shared_bit_eight, command_in_low, data_in_low} = pins;
  initial begin
    host_load_strobe = 1'b0;
    pins = 12'h000;
  end
  // Shared pins carry data or command by split
  function automatic logic [11:0] map_pins(input stpi_pkg::stpi_word_t w);
    case (split)
      2'b00: return {w.cmd[2], w.cmd[3], w.cmd[1:0], w.data[7:0]};
      2'b01: return {w.cmd[2], w.data[8], w.cmd[1:0], w.data[7:0]};
      default: return {w.data[9:8], w.cmd[1:0], w.data[7:0]};
    endcase
  endfunction
  // Hold strobe and bits until ack is seen or the wait runs out
  task automatic send(input stpi_pkg::stpi_word_t w, input int max_wait,
                      output logic got, output int waited);
    waited = 0;
    pins <= map_pins(w);
    host_load_strobe <= 1'b1;
    do begin
      @(posedge mclk);
      waited++;
    end while (host_ack !== 1'b1 && waited < max_wait);
    got = (host_ack === 1'b1);
    host_load_strobe <= 1'b0;
    pins <= ~map_pins(w);  // Released bits stop showing the word
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### tb/stpi_port_test.sv
// Self-checking bench for the host input port
`timescale 1ns/1ps
`default_nettype none
module stpi_port_test;
  localparam int LOCK = 10;  // Short relock keeps the run brief
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] split = 2'b00;
  logic [1:0] mode = 2'b00;
  logic ext_clk = 1'b0;  // Pin clock source in test modes
  logic pull_low = 1'b0;  // Open-drain pull on the relock pin
  logic [3:0] adr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic strobe, b8, b9, ack, pin_out, pin_oe, pll_out, pll_oe, serial;
  logic [7:0] dlow;
  logic [1:0] clow;
  wire logic clk_pin = pin_oe ? pin_out : ext_clk;
  wire logic pll_pin = !(pull_low || (pll_oe && !pll_out));
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int fall_cyc = 0;  // Edge count at the last byte clock fall
  logic pin_seen = 1'b0;
  logic ser_q = 1'b0;  // Line level one edge ago
  int flips = 0;  // Line transitions seen
  always #2.5 mclk = ~mclk;
  always #10 ext_clk = ~ext_clk;
  stpi_port #(.LOCK_CYC(LOCK)) uut (
    .mclk(mclk), .rst_b(rst_b), .host_load_strobe(strobe), .data_in_low(dlow),
    .command_in_low(clow), .shared_bit_eight(b8), .shared_bit_nine(b9), .host_ack(ack),
    .width_split_select(split), .test_or_normal_select(mode), .clk_pin_in(clk_pin),
    .clk_pin_out(pin_out), .clk_pin_oe(pin_oe), .pll_reset_in(pll_pin),
    .pll_reset_out(pll_out), .pll_reset_oe(pll_oe), .serial_out(serial),
    .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq));
  stpi_host_model host (
    .mclk(mclk), .split(split), .host_load_strobe(strobe), .data_in_low(dlow),
    .command_in_low(clow), .shared_bit_eight(b8), .shared_bit_nine(b9), .host_ack(ack));
  // Track byte clock falls and line transitions
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    pin_seen <= pin_out;
    ser_q <= serial;
    if (ser_q !== serial) flips <= flips + 1;
    if (pin_seen === 1'b1 && pin_out === 1'b0) fall_cyc <= cyc;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string what);
    bad_count++;
    $display("ERROR t=%0t %s", $time, what);
    report_and_stop();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr_en <= wr;
    rd_en <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rd = rdat;
    if (n >= 50) fail("bus timeout");
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask
  // Edges between two byte clock falls
  task automatic measure(output int per);
    int f0;
    int n;
    n = 0;
    f0 = fall_cyc;
    while (fall_cyc == f0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    f0 = fall_cyc;
    while (fall_cyc == f0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400) fail("byte clock stopped");
    per = fall_cyc - f0;
  endtask
  function automatic int byte_cyc(input logic [1:0] s);
    return (s == 2'b00 ? 10 : s == 2'b01 ? 11 : 12) * stpi_pkg::STPI_BIT_CYC;
  endfunction
  // Line toggles per idle byte in the 8/4 and 10/2 splits: NRZI flips once for each one bit of the sync code
  function automatic int sync_ones(input logic [1:0] s);
    return s == 2'b00 ? $countones({stpi_pkg::STPI_SYNC5_HI, stpi_pkg::STPI_SYNC5_LO})
      : $countones({stpi_pkg::STPI_SYNC6_HI, stpi_pkg::STPI_SYNC6_LO});
  endfunction
  // Random word fitting the split; half draw command bits, which can come out zero
  function automatic stpi_pkg::stpi_word_t rand_word(input logic [1:0] s);
    stpi_pkg::stpi_word_t w;
    w.data = 10'($urandom) & (s == 2'b00 ? 10'h0ff : s == 2'b01 ? 10'h1ff : 10'h3ff);
    w.cmd = ($urandom % 2) ? 4'($urandom) & (s == 2'b00 ? 4'hf : s == 2'b01 ? 4'h7 : 4'h3) : 4'h0;
    w.is_cmd = (w.cmd != 4'h0);
    return w;
  endfunction
  initial begin
    logic [31:0] rd;
    logic [31:0] c0;
    logic got;
    int per;
    int w;
    int f1;
    void'($urandom(32'h664b691d));
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2 * LOCK) @(posedge mclk);
    bus(1'b1, 4'hc, 32'h0000_0000, rd);
    bus(1'b0, 4'h0, 32'h0000_0000, rd);
    check(rd, stpi_pkg::STPI_CTRL_RST, "control reset");
    bus(1'b0, 4'hc, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    for (int s = 0; s < 3; s++) begin
      split <= 2'(s);
      measure(per);
      measure(per);
      check(32'(per), 32'(byte_cyc(split)), "byte period");
      bus(1'b0, 4'h8, 32'h0000_0000, c0);
      bus(1'b1, 4'h0, 32'h0000_0000, rd);  // Stall the encoder
      for (int i = 0; i < 4; i++) begin
        host.send(rand_word(split), 150, got, w);
        check({31'h0, got}, {31'h0, i < 3}, "ack given");
        if (i == 0) check(32'(w <= 2), 32'h1, "quick ack");
        else if (got) check(32'(cyc - fall_cyc <= 5), 32'h1, "ack after fall");
      end
      bus(1'b0, 4'h4, 32'h0000_0000, rd);
      check({27'h0, rd[7:6], rd[2:0]}, {27'h0, split, 3'b101}, "latch full");
      // Stalled encoder sends only syncs: any two-byte window has a fixed toggle count
      f1 = flips;
      repeat (2 * byte_cyc(split)) @(posedge mclk);
      if (s != 1) check(32'(flips - f1), 32'(2 * sync_ones(split)), "idle line");
      bus(1'b1, 4'h0, 32'h0000_0001, rd);  // Resume draining
      repeat (6 * byte_cyc(split)) @(posedge mclk);
      bus(1'b0, 4'h8, 32'h0000_0000, rd);
      check({16'h0, rd[15:0] - c0[15:0]}, 32'h3, "bytes sent");
    end
    for (int m = 3; m >= 0; m--) begin
      mode <= 2'(m);
      repeat (3) @(posedge mclk);
      check({31'h0, pin_oe}, {31'h0, m == 0}, "clock pin direction");
    end
    repeat (2 * LOCK) @(posedge mclk);
    pull_low <= 1'b1;
    repeat (3) @(posedge mclk);
    pull_low <= 1'b0;
    bus(1'b0, 4'h4, 32'h0000_0000, rd);
    check({31'h0, rd[3]}, 32'h0, "relocking");
    repeat (3 * LOCK) @(posedge mclk);
    bus(1'b0, 4'h4, 32'h0000_0000, rd);
    check({31'h0, rd[3]}, 32'h1, "locked again");
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fail("run time limit");
  end
endmodule
bind stpi_port stpi_port_properties chk (
  .mclk(mclk), .rst_b(rst_b), .host_load_strobe(host_load_strobe), .host_ack(host_ack),
  .test_or_normal_select(test_or_normal_select), .clk_pin_oe(clk_pin_oe),
  .pll_reset_oe(pll_reset_oe), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
